// File: core/idb_pkg.sv
// Package: descriptor field layout and encodings for the receive descriptor builder
package idb_pkg;
  // ********************************************************************
  // Word 0 field positions
  // ********************************************************************
  localparam int COUNT_LSB = 0;        // Part byte count low bit
  localparam int COUNT_W = 13;         // Part byte count width
  localparam int RES_LSB = 13;         // Reserved pair low bit
  localparam int COPY_BIT = 15;        // Copy decision bit
  localparam int C_LSB = 16;           // C indicator
  localparam int A_LSB = 18;           // A indicator
  localparam int E_LSB = 20;           // E indicator
  localparam int FCS_OK_BIT = 22;      // Check sequence valid
  localparam int VLEN_BIT = 23;        // Length valid
  localparam int TERM_LSB = 24;        // Termination condition
  localparam int AMATCH_BIT = 26;      // Address match flag
  localparam int OWN_BIT = 27;         // Own frame flag
  localparam int STAT_LSB = 28;        // Indicate status code
  localparam int ADDR_W = 28;          // Part start address width
  // Pad bytes written but not counted
  localparam logic [12:0] PAD_BYTES = 13'h0003;
  // Termination condition codes
  localparam logic [1:0] TERM_OTHER = 2'h0;
  localparam logic [1:0] TERM_ED = 2'h1;
  // Indicator encoding none
  localparam logic [1:0] IND_NONE = 2'h0;
  // Reset value of descriptor words
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage

// File: core/idb_status_pri.sv
// Priority selector of the four-bit indicate status code
`timescale 1ns/1ps
`default_nettype none
module idb_status_pri (
  // Condition requests, bit n asks for code n
  input wire logic [15:0] i_cond,
  // Selected code and any-condition flag
  output logic [3:0] o_code,
  output logic o_any
);
  // ********************************************************************
  // Highest numbered condition wins
  // ********************************************************************
  always_comb begin
    o_code = 4'h0;
    o_any = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i_cond[i]) begin
        o_code = 4'(i);
        o_any = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/idb_builder.sv
// Receive part descriptor builder top level
// Summary of operation
// - One descriptor per stored receive data part
// - Same status logic each part; last flag not used
// - Bits 12:0 count bytes including FCS
// - Three pad bytes stored, not counted
// - Bit 15 mirrors copy decision signal
// - Indicators meaningful only on ending delimiter
// - C, A, E two-bit indicator fields
// - Bit 22 flags check sequence valid
// - Bit 23 flags data length valid
// - Bits 25:24 hold termination condition
// - Bit 26 holds sampled address match
// - Bit 27 holds sampled own frame
// - Highest numbered status code reported
// - Status code groups by meaning
// - Word 1 bits 27:0 part address
`timescale 1ns/1ps
`default_nettype none
module idb_builder (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Part completion request
  input wire logic i_part_valid,
  input wire logic i_part_last,
  input wire logic [12:0] i_part_bytes,
  input wire logic [27:0] i_part_start_address,
  input wire logic [15:0] i_status_cond,
  // Frame attributes from the ring side
  input wire logic i_copy_decision_signal,
  input wire logic [1:0] i_termination_condition,
  input wire logic [1:0] i_c_ind,
  input wire logic [1:0] i_a_ind,
  input wire logic [1:0] i_e_ind,
  input wire logic i_check_sequence_valid,
  input wire logic i_length_valid,
  // External flag pins, sampled at frame receive
  input wire logic i_address_match_flag,
  input wire logic i_own_frame_flag,
  input wire logic i_frame_rcvd,
  // Descriptor output
  output logic o_desc_valid,
  output logic [31:0] o_desc_word0,
  output logic [31:0] o_desc_word1
);
  import idb_pkg::*;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [2:0] amatch_sync_reg; // Address match pin stages
  logic [2:0] own_sync_reg;    // Own frame pin stages
  logic amatch_reg;            // Debounced address match level
  logic own_reg;               // Debounced own frame level
  logic amatch_smp_reg;        // Latched at frame receive
  logic own_smp_reg;           // Latched at frame receive

  // Three stages per pin
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      amatch_sync_reg <= 3'h0;
      own_sync_reg <= 3'h0;
    end else begin
      amatch_sync_reg <= {amatch_sync_reg[1:0], i_address_match_flag};
      own_sync_reg <= {own_sync_reg[1:0], i_own_frame_flag};
    end
  end

  // Level changes once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      amatch_reg <= 1'b0;
      own_reg <= 1'b0;
    end else begin
      if (amatch_sync_reg[1] == amatch_sync_reg[2]) begin
        amatch_reg <= amatch_sync_reg[2];
      end
      if (own_sync_reg[1] == own_sync_reg[2]) begin
        own_reg <= own_sync_reg[2];
      end
    end
  end

  // Capture flags when the frame is received
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      amatch_smp_reg <= 1'b0;
      own_smp_reg <= 1'b0;
    end else if (i_frame_rcvd) begin
      amatch_smp_reg <= amatch_reg;
      own_smp_reg <= own_reg;
    end
  end

  // ********************************************************************
  // Status code selection
  // ********************************************************************
  logic [3:0] stat_code; // Prioritised status code
  logic stat_any;        // Some condition raised

  // Code groups: 0-3 mid frame, 4-7 normal, 8-b abort, c-f error
  idb_status_pri u_pri (
    .i_cond(i_status_cond),
    .o_code(stat_code),
    .o_any(stat_any)
  );

  // ********************************************************************
  // Descriptor assembly
  // ********************************************************************
  logic [31:0] word0_next; // Assembled word 0
  logic [12:0] count_next; // Reported byte count
  logic ed_end;            // Frame ended by ending delimiter

  // Build word 0 from the part and frame status
  always_comb begin
    word0_next = WORD_RST;
    ed_end = (i_termination_condition == TERM_ED);
    // Pad bytes are excluded; data count includes FCS
    if (i_part_bytes >= PAD_BYTES) begin
      count_next = i_part_bytes - PAD_BYTES;
    end else begin
      count_next = 13'h0000;
    end
    word0_next[COUNT_LSB +: COUNT_W] = count_next;
    word0_next[COPY_BIT] = i_copy_decision_signal;
    // Indicators only when terminated by delimiter
    if (ed_end) begin
      word0_next[C_LSB +: 2] = i_c_ind;
      word0_next[A_LSB +: 2] = i_a_ind;
      word0_next[E_LSB +: 2] = i_e_ind;
    end else begin
      word0_next[C_LSB +: 2] = IND_NONE;
      word0_next[A_LSB +: 2] = IND_NONE;
      word0_next[E_LSB +: 2] = IND_NONE;
    end
    word0_next[FCS_OK_BIT] = i_check_sequence_valid;
    word0_next[VLEN_BIT] = i_length_valid;
    word0_next[TERM_LSB +: 2] = i_termination_condition;
    word0_next[AMATCH_BIT] = amatch_smp_reg;
    word0_next[OWN_BIT] = own_smp_reg;
    word0_next[STAT_LSB +: 4] = stat_code;
  end

  // Store one descriptor per completed part
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_desc_word0 <= WORD_RST;
      o_desc_word1 <= WORD_RST;
    end else if (i_part_valid) begin
      o_desc_word0 <= word0_next;
      o_desc_word1 <= {4'h0, i_part_start_address};
    end
  end

  // One-cycle strobe per descriptor
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_desc_valid <= 1'b0;
    end else begin
      o_desc_valid <= i_part_valid;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  a_one_per_part: assert property (@(posedge i_clk) disable iff (i_srst)
    i_part_valid |=> o_desc_valid)
    else $error("descriptor missing after part");
  a_no_spurious: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_part_valid |=> !o_desc_valid)
    else $error("descriptor without part");
  a_count_pad: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_part_valid && i_part_bytes >= PAD_BYTES) |=>
    o_desc_word0[12:0] == $past(i_part_bytes) - PAD_BYTES)
    else $error("byte count wrong");
  // Parts shorter than the pad report an empty count
  a_count_floor: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_part_valid && i_part_bytes < PAD_BYTES) |=>
    o_desc_word0[12:0] == 13'h0000)
    else $error("short count not zero");
  a_copy_bit: assert property (@(posedge i_clk) disable iff (i_srst)
    i_part_valid |=> o_desc_word0[15] == $past(i_copy_decision_signal))
    else $error("copy bit wrong");
  a_ind_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_part_valid && i_termination_condition != TERM_ED) |=>
    o_desc_word0[21:16] == 6'h00)
    else $error("indicators without delimiter");
  a_ind_pass: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_part_valid && i_termination_condition == TERM_ED) |=>
    o_desc_word0[17:16] == $past(i_c_ind) &&
    o_desc_word0[19:18] == $past(i_a_ind) &&
    o_desc_word0[21:20] == $past(i_e_ind))
    else $error("indicator field wrong");
  a_valid_bits: assert property (@(posedge i_clk) disable iff (i_srst)
    i_part_valid |=> o_desc_word0[22] == $past(i_check_sequence_valid) &&
    o_desc_word0[23] == $past(i_length_valid))
    else $error("validity bits wrong");
  a_term_field: assert property (@(posedge i_clk) disable iff (i_srst)
    i_part_valid |=> o_desc_word0[25:24] == $past(i_termination_condition))
    else $error("termination field wrong");
  a_flag_bits: assert property (@(posedge i_clk) disable iff (i_srst)
    i_part_valid |=> o_desc_word0[26] == $past(amatch_smp_reg) &&
    o_desc_word0[27] == $past(own_smp_reg))
    else $error("flag bits wrong");
  a_status_max: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_part_valid && i_status_cond[15]) |=> o_desc_word0[31:28] == 4'hf)
    else $error("status priority wrong");
  // No condition raised leaves the code at zero
  a_status_none: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_part_valid && i_status_cond == 16'h0000) |=>
    o_desc_word0[31:28] == 4'h0)
    else $error("status without condition");
  // Any error condition lands in the error group
  a_code_group: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_part_valid && |i_status_cond[15:12]) |=>
    o_desc_word0[31:30] == 2'h3)
    else $error("error group not reported");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    o_desc_valid |-> o_desc_word0[14:13] == 2'h0 &&
    o_desc_word1[31:28] == 4'h0)
    else $error("reserved bits not zero");
  a_part_addr: assert property (@(posedge i_clk) disable iff (i_srst)
    i_part_valid |=> o_desc_word1[27:0] == $past(i_part_start_address))
    else $error("address wrong");

  c_multi_part: cover property (@(posedge i_clk) disable iff (i_srst)
    (i_part_valid && !i_part_last) ##1 (i_part_valid && i_part_last));
  c_ed_end: cover property (@(posedge i_clk) disable iff (i_srst)
    i_part_valid && i_termination_condition == 2'h1 && stat_any);
  c_error_code: cover property (@(posedge i_clk) disable iff (i_srst)
    i_part_valid && stat_code[3:2] == 2'h3);
endmodule
`default_nettype wire

// File: bench/idb_host_model.sv
// Host side model that stores each descriptor the device hands it
`timescale 1ns/1ps
`default_nettype none
module idb_host_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Descriptor store from the device
  input wire logic i_desc_valid,
  input wire logic [31:0] i_desc_word0,
  input wire logic [31:0] i_desc_word1,
  // Descriptor as the host reads it back
  output logic o_got,
  output logic [31:0] o_word0,
  output logic [31:0] o_word1
);
  // Take each descriptor in the one cycle it stands
  always_ff @(posedge i_clk) begin
    o_got <= i_desc_valid & ~i_srst;
    if (i_desc_valid) begin
      o_word0 <= i_desc_word0;
      o_word1 <= i_desc_word1;
    end
  end
endmodule
`default_nettype wire

// File: bench/idb_builder_bench.sv
// Self-checking bench for the receive part descriptor builder
`timescale 1ns/1ps
`default_nettype none
module idb_builder_bench;
  // Stimulus, outputs and scoreboard state
  logic clk, srst, pv, pl, cp, fcs, len, am, own, fr, got, dv;
  logic am_x, own_x;
  logic [12:0] nb;
  logic [27:0] ad;
  logic [15:0] cnd;
  logic [1:0] trm, ci, ai, ei;
  logic [31:0] dw0, dw1, hw0, hw1, seed, e0, rv;
  logic [31:0] q0[$], q1[$];
  logic [12:0] bt[4];
  int mismatches, compares;
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  idb_builder u_dut (.i_clk(clk), .i_srst(srst), .i_part_valid(pv),
    .i_part_last(pl), .i_part_bytes(nb), .i_part_start_address(ad),
    .i_status_cond(cnd), .i_copy_decision_signal(cp),
    .i_termination_condition(trm), .i_c_ind(ci), .i_a_ind(ai),
    .i_e_ind(ei), .i_check_sequence_valid(fcs), .i_length_valid(len),
    .i_address_match_flag(am), .i_own_frame_flag(own), .i_frame_rcvd(fr),
    .o_desc_valid(dv), .o_desc_word0(dw0), .o_desc_word1(dw1));
  idb_host_model u_host (.i_clk(clk), .i_srst(srst), .i_desc_valid(dv),
    .i_desc_word0(dw0), .i_desc_word1(dw1), .o_got(got), .o_word0(hw0),
    .o_word1(hw1));
  // Next pseudo random word
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
    return seed;
  endfunction
  // Compare one descriptor word
  task automatic cmp32(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Flag pins held stable, then sampled by the receive pulse
  task automatic set_flags();
    logic [31:0] r;
    r = rnd();
    am_x = r[0];
    own_x = r[1];
    am <= am_x;
    own <= own_x;
    repeat (5) @(posedge clk);
    fr <= 1'b1;
    @(posedge clk);
    fr <= 1'b0;
    @(posedge clk);
  endtask
  // One part request; expected words noted in the queue
  task automatic send_part(input logic [12:0] b, input logic [15:0] c);
    logic [31:0] r, a;
    logic [3:0] code;
    r = rnd();
    a = rnd();
    code = 4'h0;
    for (int n = 0; n < 16; n++) if (c[n]) code = n[3:0];
    pv <= 1'b1;
    pl <= r[12];
    nb <= b;
    ad <= a[27:0];
    cnd <= c;
    cp <= r[3];
    fcs <= r[4];
    len <= r[5];
    ci <= r[7:6];
    ai <= r[9:8];
    ei <= r[11:10];
    trm <= r[14:13];
    q0.push_back({code, own_x, am_x, r[14:13], r[5], r[4],
      (r[14:13] == 2'h1) ? r[11:6] : 6'h00, r[3], 2'h0,
      (b < 13'h0003) ? 13'h0000 : b - 13'h0003});
    q1.push_back({4'h0, a[27:0]});
    @(posedge clk);
  endtask
  // Scoreboard: oldest note against each stored descriptor
  always @(negedge clk) begin
    if (got === 1'b1) begin
      if (q0.size() == 0) begin
        cmp32("extra", 32'h0000_0000, 32'h0000_0001);
      end else begin
        e0 = q0.pop_front();
        cmp32("count", e0 & 32'h0000_1fff, hw0 & 32'h0000_1fff);
        cmp32("reserved", e0 & 32'h0000_6000, hw0 & 32'h0000_6000);
        cmp32("copy", e0 & 32'h0000_8000, hw0 & 32'h0000_8000);
        cmp32("ind", e0 & 32'h003f_0000, hw0 & 32'h003f_0000);
        cmp32("valid", e0 & 32'h00c0_0000, hw0 & 32'h00c0_0000);
        cmp32("term", e0 & 32'h0300_0000, hw0 & 32'h0300_0000);
        cmp32("flags", e0 & 32'h0c00_0000, hw0 & 32'h0c00_0000);
        cmp32("status", e0 & 32'hf000_0000, hw0 & 32'hf000_0000);
        cmp32("word1", q1.pop_front(), hw1);
      end
    end
  end
  // Outputs cleared by reset, looked at just after release
  task automatic chk_reset();
    @(negedge clk);
    cmp32("rst_word0", 32'h0000_0000, dw0);
    cmp32("rst_word1", 32'h0000_0000, dw1);
    cmp32("rst_valid", 32'h0000_0000, {31'h0, dv});
    @(posedge clk);
  endtask
  // Main sequence
  initial begin
    seed = 32'h5be5_0892;
    bt = '{13'h0000, 13'h0002, 13'h0003, 13'h1fff};
    {srst, pv, pl, cp, fcs, len, am, own, fr} = 9'h100;
    {nb, ad, cnd, trm, ci, ai, ei} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    chk_reset();
    for (int f = 0; f < 10; f++) begin
      set_flags();
      for (int p = 0; p < 4; p++) begin
        rv = rnd();
        if (f == 0) begin
          send_part(bt[p], 16'h0001 << p);
        end else if (f < 4) begin
          send_part(rv[12:0], 16'h0001 << (4 * f + p));
        end else begin
          send_part(rv[12:0], rv[31:16] & {16{rv[13]}});
        end
      end
      pv <= 1'b0;
    end
    for (int w = 0; w < 8 && q0.size() > 0; w++) @(posedge clk);
    if (q0.size() > 0) cmp32("missing", 32'h0000_0000, q0.size());
    // Reset in mid-run must clear the words left by traffic
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
